// ### pss_pkg.sv
package pss_pkg;
  // setting word layout and the sub-address window
  localparam int SUB_HI = 31;
  localparam int SUB_LO = 24;
  localparam int DATA_W = 24;
  localparam logic [7:0] SUB_FIRST = 8'h90;
  localparam logic [7:0] SUB_LAST = 8'h9a;
  localparam int NUM_SET = 11;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h90;
  localparam logic [7:0] IDX_TAU_ROUTE = 8'h91;
  localparam logic [7:0] IDX_LEN = 8'h92;
  localparam logic [7:0] IDX_T2A_LO = 8'h93;
  localparam logic [7:0] IDX_T2A_HI = 8'h94;
  localparam logic [7:0] IDX_A2T_FIRST = 8'h95;
  localparam logic [7:0] IDX_A2T_LAST = 8'h9a;
  localparam logic [23:0] SET_RESET = 24'h000000;
  // writable bits per setting, reserved bits stay zero
  localparam logic [23:0] MASK_FULL = 24'hffffff;
  localparam logic [23:0] MASK_TAU_ROUTE = 24'h80ffff;
  localparam logic [23:0] MASK_LEN = 24'h3fc1ff;
  localparam logic [23:0] MASK_LOW_BYTE = 24'h0000ff;
  // field positions of the control, routing and lengths words
  localparam int B_ARITH_OUTPUT_MARKER_DIS = 23;
  localparam int B_SW_DEP = 22;
  localparam int B_NO_DEP_TAU = 21;
  localparam int B_NO_DEP_KILL = 20;
  localparam int B_LOCATION = 19;
  localparam int B_START_ALU = 18;
  localparam int B_CST_MIRROR = 17;
  localparam int B_PART_HI = 16;
  localparam int B_PART_LO = 15;
  localparam int B_TEX14_ALU = 14;
  localparam int B_TEX15_ALU = 23;
  localparam int B_TEX15_TAU = 15;
  localparam int B_TAU_LEN_HI = 21;
  localparam int B_TAU_LEN_LO = 16;
  localparam int B_SWAP_T2A = 15;
  localparam int B_SWAP_A2T = 14;
  localparam int B_ALU_LEN_HI = 8;
  // switch vectors and constant mirroring
  localparam int T2A_BITS = 32;
  localparam int A2T_BITS = 128;
  localparam logic [5:0] CST_MIRROR_LAST = 6'h16;
  localparam logic [5:0] CST_MIRROR_OFS = 6'h20;
  localparam int CST_W = 32;
  // bus decode
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    PSS_IDLE = 3'h1,
    PSS_TAU = 3'h2,
    PSS_ALU = 3'h4
  } pss_seq_t;

  typedef struct packed {
    logic alu_out_hw_detect;
    logic dependent_tau;
    logic texkill_dep_enable;
    logic location_reg_enable;
    logic start_with_alu;
    logic constant_mirror_enable;
    logic [1:0] register_partition_mode;
    logic [4:0] tex_reg_count;
    logic [3:0] temp_reg_count;
    logic [15:0] tex_to_alu;
    logic [15:0] tex_to_texaddr;
  } pss_cfg_t;

  typedef struct packed {
    logic valid;
    logic is_alu;
    logic [8:0] idx;
    logic swap_tex_to_internal;
    logic swap_internal_to_tex;
    logic pixel_done;
  } pss_issue_t;

  typedef struct packed {
    logic valid;
    logic [5:0] idx;
    logic [CST_W-1:0] data;
    logic dup_valid;
    logic [5:0] dup_idx;
  } pss_cst_t;
endpackage

// ### pss_sequencer_config.sv
`timescale 1ns/1ps
// Contract
// - accept setting words within the sub-address window
// - bit23 selects hardware or software output marking
// - bit22: hardware or software dependency judgement
// - bit21 zero means dependent texture instruction
// - bit20 set suppresses dependent texture kill
// - bit19 enables location register fetch
// - bit18 picks first unit, default texture
// - bit17 mirrors constant n into n+32, for n up to 22
// - bits16:15 choose register partition
// - bits14:0 route texture registers to arithmetic
// - routing word bit23 routes texture 15 to arithmetic
// - routing word bits15:0 route textures to address unit
// - lengths word bits21:16 texture program length
// - lengths word bits8:0 arithmetic program length
// - bit15 swaps texture into internal at switch
// - bit14 swaps internal into texture at switch
// - low switch word bit n switches to arithmetic
// - later bits switch back to texture unit
module pss_sequencer_config (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic set_valid,
  input wire logic [31:0] set_word,
  output logic set_ready,
  input wire logic pixel_start,
  output logic pixel_ready,
  output pss_pkg::pss_issue_t issue,
  input wire logic cst_in_valid,
  input wire logic [5:0] cst_in_idx,
  input wire logic [pss_pkg::CST_W-1:0] cst_in_data,
  output pss_pkg::pss_cst_t cst_out,
  output pss_pkg::pss_cfg_t cfg
);

  typedef struct packed {
    logic [pss_pkg::NUM_SET-1:0][pss_pkg::DATA_W-1:0] set;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
    pss_pkg::pss_seq_t seq;
    logic [5:0] tau_cnt;
    logic [8:0] alu_cnt;
    pss_pkg::pss_issue_t issue;
    pss_pkg::pss_cst_t cst;
    pss_pkg::pss_cfg_t cfg;
  } pss_state_t;

  pss_state_t cur_ff;
  pss_state_t nxt_cur;

  // true when an index falls inside the setting window
  function automatic logic in_window(input logic [7:0] idx);
    in_window = (idx >= pss_pkg::SUB_FIRST) && (idx <= pss_pkg::SUB_LAST);
  endfunction

  // storage slot of a setting index
  function automatic logic [3:0] slot(input logic [7:0] idx);
    logic [7:0] d;
    d = idx - pss_pkg::SUB_FIRST;
    slot = d[3:0];
  endfunction

  // writable bits of each setting
  function automatic logic [23:0] wmask(input logic [7:0] idx);
    case (idx)
      pss_pkg::IDX_TAU_ROUTE: wmask = pss_pkg::MASK_TAU_ROUTE;
      pss_pkg::IDX_LEN: wmask = pss_pkg::MASK_LEN;
      pss_pkg::IDX_T2A_HI: wmask = pss_pkg::MASK_LOW_BYTE;
      pss_pkg::IDX_A2T_LAST: wmask = pss_pkg::MASK_LOW_BYTE;
      default: wmask = pss_pkg::MASK_FULL;
    endcase
  endfunction

  // bus byte address to setting index, zero when unmapped
  function automatic logic [7:0] bus_idx(input logic [31:0] a);
    if (a[31:10] == 22'h000000 && a[1:0] == 2'h0 && in_window(a[9:2])) begin
      bus_idx = a[9:2];
    end else begin
      bus_idx = 8'h00;
    end
  endfunction

  logic [23:0] w_ctrl;
  logic [23:0] w_route;
  logic [23:0] w_len;
  logic [pss_pkg::T2A_BITS-1:0] t2a_vec;
  logic [pss_pkg::A2T_BITS-1:0] a2t_vec;
  logic [5:0] tau_len;
  logic [8:0] alu_len;
  logic [7:0] a_idx;
  logic [4:0] tex_n;
  logic [3:0] temp_n;

  // decoded views of the stored settings
  assign w_ctrl = cur_ff.set[slot(pss_pkg::IDX_CTRL)];
  assign w_route = cur_ff.set[slot(pss_pkg::IDX_TAU_ROUTE)];
  assign w_len = cur_ff.set[slot(pss_pkg::IDX_LEN)];
  assign t2a_vec = {cur_ff.set[slot(pss_pkg::IDX_T2A_HI)][7:0],
                    cur_ff.set[slot(pss_pkg::IDX_T2A_LO)]};
  assign a2t_vec = {cur_ff.set[10][7:0], cur_ff.set[9], cur_ff.set[8],
                    cur_ff.set[7], cur_ff.set[6], cur_ff.set[5]};
  assign tau_len = w_len[pss_pkg::B_TAU_LEN_HI:pss_pkg::B_TAU_LEN_LO];
  assign alu_len = w_len[pss_pkg::B_ALU_LEN_HI:0];
  assign a_idx = bus_idx(haddr);

  // register partition lookup
  always_comb begin
    case (w_ctrl[pss_pkg::B_PART_HI:pss_pkg::B_PART_LO])
      2'h0: begin
        tex_n = 5'h10;
        temp_n = 4'hc;
      end
      2'h1: begin
        tex_n = 5'h08;
        temp_n = 4'h6;
      end
      2'h2: begin
        tex_n = 5'h05;
        temp_n = 4'h4;
      end
      default: begin
        tex_n = 5'h04;
        temp_n = 4'h3;
      end
    endcase
  end

  // next state of settings, bus, sequencer and constant path
  always_comb begin
    logic [7:0] sidx;
    logic tau_last;
    logic alu_last;
    logic sw;
    logic [5:0] tn;
    logic [8:0] an;
    sidx = set_word[pss_pkg::SUB_HI:pss_pkg::SUB_LO];
    tau_last = 1'b0;
    alu_last = 1'b0;
    sw = 1'b0;
    tn = 6'h00;
    an = 9'h000;
    nxt_cur = cur_ff;
    // setting words from the command stream
    if (set_valid && in_window(sidx)) begin
      nxt_cur.set[slot(sidx)] = set_word[pss_pkg::DATA_W-1:0] & wmask(sidx);
    end
    // bus write data phase wins over a same-cycle setting word
    if (cur_ff.wr_pend) begin
      nxt_cur.set[slot(cur_ff.wr_idx)] = hwdata[pss_pkg::DATA_W-1:0] & wmask(cur_ff.wr_idx);
    end
    // bus address phase
    nxt_cur.wr_pend = 1'b0;
    if (hsel && hready && htrans == pss_pkg::HTRANS_NONSEQ) begin
      if (hwrite) begin
        nxt_cur.wr_pend = (a_idx != 8'h00);
        nxt_cur.wr_idx = a_idx;
      end else if (a_idx != 8'h00) begin
        nxt_cur.rdata = {8'h00, nxt_cur.set[slot(a_idx)]};
      end else begin
        nxt_cur.rdata = 32'h00000000;
      end
    end
    // constant writes, indices up to 22 mirrored into the upper half when enabled
    nxt_cur.cst.valid = cst_in_valid;
    nxt_cur.cst.idx = cst_in_idx;
    nxt_cur.cst.data = cst_in_data;
    nxt_cur.cst.dup_valid = cst_in_valid && w_ctrl[pss_pkg::B_CST_MIRROR]
                            && (cst_in_idx <= pss_pkg::CST_MIRROR_LAST);
    nxt_cur.cst.dup_idx = cst_in_idx + pss_pkg::CST_MIRROR_OFS;
    // configuration outputs
    nxt_cur.cfg.alu_out_hw_detect = ~w_ctrl[pss_pkg::B_ARITH_OUTPUT_MARKER_DIS];
    if (w_ctrl[pss_pkg::B_SW_DEP]) begin
      nxt_cur.cfg.dependent_tau = ~w_ctrl[pss_pkg::B_NO_DEP_TAU];
    end else begin
      nxt_cur.cfg.dependent_tau = (|a2t_vec) | w_ctrl[pss_pkg::B_START_ALU];
    end
    nxt_cur.cfg.texkill_dep_enable = ~w_ctrl[pss_pkg::B_NO_DEP_KILL];
    nxt_cur.cfg.location_reg_enable = w_ctrl[pss_pkg::B_LOCATION];
    nxt_cur.cfg.start_with_alu = w_ctrl[pss_pkg::B_START_ALU];
    nxt_cur.cfg.constant_mirror_enable = w_ctrl[pss_pkg::B_CST_MIRROR];
    nxt_cur.cfg.register_partition_mode = w_ctrl[pss_pkg::B_PART_HI:pss_pkg::B_PART_LO];
    nxt_cur.cfg.tex_reg_count = tex_n;
    nxt_cur.cfg.temp_reg_count = temp_n;
    nxt_cur.cfg.tex_to_alu = {w_route[pss_pkg::B_TEX15_ALU],
                              w_ctrl[pss_pkg::B_TEX14_ALU:0]};
    nxt_cur.cfg.tex_to_texaddr = w_route[pss_pkg::B_TEX15_TAU:0];
    // sequencer, one instruction per cycle
    nxt_cur.issue = '0;
    case (cur_ff.seq)
      pss_pkg::PSS_IDLE: begin
        if (pixel_start) begin
          if (tau_len == 6'h00 && alu_len == 9'h000) begin
            nxt_cur.issue.pixel_done = 1'b1;
          end else if ((w_ctrl[pss_pkg::B_START_ALU] && alu_len != 9'h000)
                       || tau_len == 6'h00) begin
            nxt_cur.seq = pss_pkg::PSS_ALU;
          end else begin
            nxt_cur.seq = pss_pkg::PSS_TAU;
          end
          nxt_cur.tau_cnt = 6'h00;
          nxt_cur.alu_cnt = 9'h000;
        end
      end
      pss_pkg::PSS_TAU: begin
        tn = cur_ff.tau_cnt + 6'h01;
        tau_last = (tn >= tau_len);
        alu_last = (cur_ff.alu_cnt >= alu_len);
        sw = t2a_vec[cur_ff.tau_cnt[4:0]] & ~cur_ff.tau_cnt[5];
        nxt_cur.issue.valid = 1'b1;
        nxt_cur.issue.idx = {3'h0, cur_ff.tau_cnt};
        nxt_cur.tau_cnt = tn;
        if (tau_last && alu_last) begin
          nxt_cur.issue.pixel_done = 1'b1;
          nxt_cur.seq = pss_pkg::PSS_IDLE;
        end else if ((sw || tau_last) && !alu_last) begin
          nxt_cur.seq = pss_pkg::PSS_ALU;
          nxt_cur.issue.swap_tex_to_internal = w_len[pss_pkg::B_SWAP_T2A];
        end
      end
      pss_pkg::PSS_ALU: begin
        an = cur_ff.alu_cnt + 9'h001;
        alu_last = (an >= alu_len);
        tau_last = (cur_ff.tau_cnt >= tau_len);
        sw = a2t_vec[cur_ff.alu_cnt[6:0]] & ~(|cur_ff.alu_cnt[8:7]);
        nxt_cur.issue.valid = 1'b1;
        nxt_cur.issue.is_alu = 1'b1;
        nxt_cur.issue.idx = cur_ff.alu_cnt;
        nxt_cur.alu_cnt = an;
        if (tau_last && alu_last) begin
          nxt_cur.issue.pixel_done = 1'b1;
          nxt_cur.seq = pss_pkg::PSS_IDLE;
        end else if ((sw || alu_last) && !tau_last) begin
          nxt_cur.seq = pss_pkg::PSS_TAU;
          nxt_cur.issue.swap_internal_to_tex = w_len[pss_pkg::B_SWAP_A2T];
        end
      end
      default: begin
        nxt_cur.seq = pss_pkg::PSS_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_ff <= '0;
      cur_ff.seq <= pss_pkg::PSS_IDLE;
      cur_ff.cfg.alu_out_hw_detect <= 1'b1;
      cur_ff.cfg.texkill_dep_enable <= 1'b1;
      cur_ff.cfg.tex_reg_count <= 5'h10;
      cur_ff.cfg.temp_reg_count <= 4'hc;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // outputs
  assign hrdata = cur_ff.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign set_ready = 1'b1;
  assign pixel_ready = (cur_ff.seq == pss_pkg::PSS_IDLE);
  assign issue = cur_ff.issue;
  assign cst_out = cur_ff.cst;
  assign cfg = cur_ff.cfg;

endmodule

// ### pss_sequencer_config_checker.sv
`timescale 1ns/1ps
module pss_sequencer_config_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic set_valid,
  input wire logic [31:0] set_word,
  input wire logic pixel_start,
  input wire logic pixel_ready,
  input wire pss_pkg::pss_issue_t issue,
  input wire logic cst_in_valid,
  input wire logic [5:0] cst_in_idx,
  input wire pss_pkg::pss_cst_t cst_out,
  input wire pss_pkg::pss_cfg_t cfg
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // bus write address phase, its data lands one edge later and beats a setting word sent in its data phase
  logic bus_wr;
  logic [1:0] pm;
  logic [23:0] w1_ff, w2_ff;
  assign bus_wr = hsel && hready && htrans == 2'h2 && hwrite;
  assign pm = cfg.register_partition_mode;
  // setting data two edges back, lined up with the cfg update
  always_ff @(posedge hclk) begin
    w1_ff <= set_word[23:0];
    w2_ff <= w1_ff;
  end
  sequence s_word(sa, ba);
    set_valid && set_word[31:24] == sa && !$past(bus_wr && haddr == ba);
  endsequence
  sequence s_start;
    pixel_start && pixel_ready;
  endsequence
  sequence s_issue;
    issue.valid || issue.pixel_done;
  endsequence
  property p_ctrl_cfg;
    s_word(8'h90, 32'h240) |-> ##2 cfg.alu_out_hw_detect == !w2_ff[23]
      && cfg.texkill_dep_enable == !w2_ff[20] && cfg.location_reg_enable == w2_ff[19]
      && cfg.start_with_alu == w2_ff[18] && cfg.constant_mirror_enable == w2_ff[17]
      && pm == w2_ff[16:15] && cfg.tex_to_alu[14:0] == w2_ff[14:0]
      && (!w2_ff[22] || cfg.dependent_tau == !w2_ff[21]);
  endproperty
  a_ctrl_cfg: assert property (p_ctrl_cfg)
    else $error("control word not reflected in cfg");
  property p_route_cfg;
    s_word(8'h91, 32'h244) |-> ##2 cfg.tex_to_alu[15] == w2_ff[23]
      && cfg.tex_to_texaddr == w2_ff[15:0];
  endproperty
  a_route_cfg: assert property (p_route_cfg)
    else $error("routing word not reflected in cfg");
  property p_partition;
    {cfg.tex_reg_count, cfg.temp_reg_count} == (pm == 2'h0 ? 9'h10c : pm == 2'h1 ? 9'h086
      : pm == 2'h2 ? 9'h054 : 9'h043);
  endproperty
  a_partition: assert property (p_partition) else $error("register counts wrong");
  property p_const_mirror;
    cst_in_valid |=> cst_out.valid && cst_out.idx == $past(cst_in_idx)
      && cst_out.dup_valid == ($past(cfg.constant_mirror_enable) && $past(cst_in_idx) <= 6'h16)
      && cst_out.dup_idx == cst_out.idx + 6'h20;
  endproperty
  a_const_mirror: assert property (p_const_mirror) else $error("constant mirror wrong");
  property p_first_issue;
    s_start |-> ##[1:2] s_issue;
  endproperty
  a_first_issue: assert property (p_first_issue) else $error("no issue after start");
  property p_no_gap;
    issue.valid && !issue.pixel_done |=> issue.valid;
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("gap inside a pixel");
  property p_done_ready;
    issue.pixel_done |-> ##[0:1] pixel_ready;
  endproperty
  a_done_ready: assert property (p_done_ready) else $error("not idle after done");
  property p_swap_t2a;
    issue.valid && issue.swap_tex_to_internal |-> !issue.is_alu ##1 (issue.valid && issue.is_alu);
  endproperty
  a_swap_t2a: assert property (p_swap_t2a) else $error("swap flag off a switch");
  property p_swap_a2t;
    issue.valid && issue.swap_internal_to_tex |-> issue.is_alu ##1 (issue.valid && !issue.is_alu);
  endproperty
  a_swap_a2t: assert property (p_swap_a2t) else $error("swap flag off a switch");
endmodule
bind pss_sequencer_config pss_sequencer_config_checker u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .set_valid(set_valid), .set_word(set_word),
  .pixel_start(pixel_start), .pixel_ready(pixel_ready), .issue(issue),
  .cst_in_valid(cst_in_valid), .cst_in_idx(cst_in_idx), .cst_out(cst_out), .cfg(cfg)
);

// ### pss_cmd_parser_model.sv
`timescale 1ns/1ps
module pss_cmd_parser_model (
  input wire logic hclk,
  output logic set_valid,
  output logic [31:0] set_word
);
  // quiet until the first word
  initial begin
    set_valid = 1'b0;
    set_word = 32'h0;
  end
  // one word per call, sub-address on top, strobe for one cycle
  task automatic send(input logic [31:0] w);
    @(posedge hclk);
    set_valid <= 1'b1;
    set_word <= w;
    @(posedge hclk);
    set_valid <= 1'b0;
    set_word <= ~w; // stale data inverted once the strobe drops
  endtask
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, set_valid, set_ready;
  logic pixel_start, pixel_ready, cst_in_valid;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] cst_in_idx;
  logic [31:0] haddr, hwdata, hrdata, set_word, cst_in_data, rd;
  pss_pkg::pss_issue_t issue;
  pss_pkg::pss_cst_t cst_out;
  pss_pkg::pss_cfg_t cfg;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] got[$];
  logic [7:0] exp_q[$];
  logic [31:0] adr[7] = '{32'h240, 32'h244, 32'h248, 32'h24c, 32'h250, 32'h268, 32'h26c};
  logic [31:0] msk[7] = '{32'hffffff, 32'h80ffff, 32'h3fc1ff, 32'hffffff, 32'hff, 32'hff, 32'h0};
  logic [8:0] cnt[4] = '{9'h10c, 9'h086, 9'h054, 9'h043};
  pss_sequencer_config dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .set_valid(set_valid), .set_word(set_word),
    .set_ready(set_ready), .pixel_start(pixel_start), .pixel_ready(pixel_ready),
    .issue(issue), .cst_in_valid(cst_in_valid), .cst_in_idx(cst_in_idx),
    .cst_in_data(cst_in_data), .cst_out(cst_out), .cfg(cfg)
  );
  pss_cmd_parser_model u_parser (.hclk(hclk), .set_valid(set_valid), .set_word(set_word));
  // clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      wrap_up();
    end
  end
  // issue log: {is_alu, idx[3:0], swap to internal, swap to texture, done}
  always @(negedge hclk) begin
    if (issue.valid || issue.pixel_done) begin
      got.push_back({issue.is_alu, issue.idx[3:0], issue.swap_tex_to_internal,
                     issue.swap_internal_to_tex, issue.pixel_done});
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // single word transfer, address phase then data phase
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({hresp, hreadyout, set_ready}, 32'h3);
  endtask
  // start a pixel, optionally poke start again while busy, compare the log
  task automatic run_pixel(input logic twice);
    got.delete();
    @(posedge hclk);
    pixel_start <= 1'b1;
    @(posedge hclk);
    pixel_start <= 1'b0;
    if (twice) begin
      @(posedge hclk);
      pixel_start <= 1'b1;
      @(posedge hclk);
      pixel_start <= 1'b0;
    end
    while (got.size() == 0 || got[got.size()-1][0] !== 1'b1) @(posedge hclk);
    repeat (3) @(posedge hclk);
    chk(got.size(), exp_q.size());
    foreach (exp_q[i]) chk(got[i], exp_q[i]);
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pixel_start = 1'b0;
    cst_in_valid = 1'b0;
    cst_in_idx = 6'h0;
    cst_in_data = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (adr[i]) begin
      xfer(1'b0, adr[i], 32'h0);
      chk(rd, 32'h0);
      xfer(1'b1, adr[i], 32'hffffffff);
      xfer(1'b0, adr[i], 32'h0);
      chk(rd, msk[i]);
    end
    u_parser.send(32'h9b000000);
    xfer(1'b0, 32'h268, 32'h0);
    chk(rd, 32'hff);
    for (int m = 0; m < 4; m++) begin
      u_parser.send({8'h90, 7'h0, m[1:0], 15'h25a5});
      repeat (2) @(posedge hclk);
      chk({cfg.tex_reg_count, cfg.temp_reg_count}, cnt[m]);
    end
    xfer(1'b0, 32'h240, 32'h0);
    chk(rd, 32'h1a5a5);
    u_parser.send(32'h9180a5a5);
    repeat (2) @(posedge hclk);
    chk(cfg.tex_to_alu, 32'ha5a5);
    chk(cfg.tex_to_texaddr, 32'ha5a5);
    u_parser.send(32'h90020000);
    for (int k = 22; k < 24; k++) begin
      @(posedge hclk);
      cst_in_valid <= 1'b1;
      cst_in_idx <= k[5:0];
      cst_in_data <= 32'h5a000000 + k;
      @(posedge hclk);
      cst_in_valid <= 1'b0;
      #1;
      chk({cst_out.dup_valid, cst_out.dup_idx}, {k == 22, k[5:0] + 6'h20});
      chk(cst_out.data, 32'h5a000000 + k);
    end
    xfer(1'b1, 32'h240, 32'h0);
    xfer(1'b1, 32'h248, 32'h03c002);
    xfer(1'b1, 32'h24c, 32'h1);
    xfer(1'b1, 32'h254, 32'h1);
    exp_q = '{8'h04, 8'h82, 8'h08, 8'h14, 8'h89};
    run_pixel(1'b1);
    chk(cfg.dependent_tau, 1'b1);
    // program without dependent texture kills, so suppression may be set
    u_parser.send(32'h90760000);
    u_parser.send(32'h92010001);
    repeat (2) @(posedge hclk);
    chk(cfg.dependent_tau, 1'b0);
    chk(cfg.texkill_dep_enable, 1'b0);
    exp_q = '{8'h80, 8'h01};
    run_pixel(1'b0);
    wrap_up();
  end
endmodule
